// >>> logic/status_flag_pkg.sv
// package: register map, field positions, reset values and carriers of the status flag block
//
// Notes on behaviour
// - bit 15 shows accumulator A overflow
// - bit 14 shows accumulator B overflow
// - bit 13 sticky A saturation, stays set
// - bit 12 sticky B saturation, stays set
// - bit 11 is OR of both overflows
// - bit 10 is OR of sticky saturations
// - bit 9 loop active, read only
// - bit 8 half carry from low-order bit
// - three-bit priority level in bits 7:5
// - software write sets sticky bits directly while bit 10 is written 1
// - clearing bit 10 clears both sticky bits
`default_nettype none

package status_flag_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] STATUS_OFF   = 12'h000;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h008;

  // ==========================================================
  // status register field positions
  localparam int ACC_A_OVF_BIT  = 15;
  localparam int ACC_B_OVF_BIT  = 14;
  localparam int ACC_A_SAT_BIT  = 13;
  localparam int ACC_B_SAT_BIT  = 12;
  localparam int ANY_OVF_BIT    = 11;
  localparam int ANY_SAT_BIT    = 10;
  localparam int LOOP_BIT       = 9;
  localparam int HALF_CARRY_BIT = 8;
  localparam int PRIO_LSB       = 5;
  localparam int PRIO_W         = 3;

  // ==========================================================
  // interrupt status / mask bit positions
  localparam int EV_OVF_A = 0;
  localparam int EV_OVF_B = 1;
  localparam int EV_SAT_A = 2;
  localparam int EV_SAT_B = 3;
  localparam int EV_W     = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0]     STATUS_RST   = 16'h0000;
  localparam logic [EV_W-1:0] IRQ_STAT_RST = 4'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [PRIO_W-1:0] PRIO_RST   = 3'h0;

  // ==========================================================
  // carriers
  typedef enum logic [1:0] {
    SIZE_WORD,
    SIZE_BYTE
  } op_size_e;

  // result of one core operation, presented for one cycle
  typedef struct packed {
    logic       valid;
    op_size_e   size;
    logic [7:0] carry_vec;  // carry out of bit i for i = 0..7
    logic       ovf_a;
    logic       ovf_b;
    logic       sat_a;
    logic       sat_b;
  } alu_result_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  // software write into the flag core
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } sr_write_s;

endpackage : status_flag_pkg

`default_nettype wire

// >>> logic/apb_reg_if.sv
// APB slave front end: decodes one transfer into a write strobe or read select
`default_nettype none

module apb_reg_if (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // bus
  input  wire status_flag_pkg::apb_req_s req,
  output status_flag_pkg::apb_rsp_s      rsp,
  // register side
  output logic                           wr_stb,
  output logic [11:0]                    wr_addr,
  output logic [31:0]                    wr_data,
  input  wire logic [31:0]               rd_data,
  input  wire logic                      addr_hit,
  output logic [11:0]                    rd_addr
);
  import status_flag_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
  } if_state_s;

  if_state_s st_ff;
  if_state_s nxt_st;
  logic      access;

  // ==========================================================
  // zero wait state access phase
  assign access  = req.psel & req.penable;
  assign wr_stb  = access & req.pwrite & addr_hit;
  assign wr_addr = req.paddr;
  assign wr_data = req.pwdata;
  assign rd_addr = req.paddr;

  always_comb begin
    nxt_st = st_ff;
    if (req.psel && !req.penable && !req.pwrite) begin
      nxt_st.prdata = addr_hit ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp.prdata  = st_ff.prdata;
  assign rsp.pready  = 1'b1;
  assign rsp.pslverr = access & ~addr_hit;

endmodule : apb_reg_if

`default_nettype wire

// >>> logic/flag_irq.sv
// sticky event status with mask and level interrupt
`default_nettype none

module flag_irq (
  // clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // events and software access
  input  wire logic [status_flag_pkg::EV_W-1:0]   events,
  input  wire logic                               stat_wr,
  input  wire logic                               mask_wr,
  input  wire logic [status_flag_pkg::EV_W-1:0]   wdata,
  // state
  output logic [status_flag_pkg::EV_W-1:0]        stat,
  output logic [status_flag_pkg::EV_W-1:0]        mask,
  output logic                                    irq
);
  import status_flag_pkg::*;

  typedef struct packed {
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic            irq;
  } irq_state_s;

  irq_state_s st_ff;
  irq_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (stat_wr) begin
      nxt_st.stat = st_ff.stat & ~wdata;
    end
    // a new event wins over a simultaneous clear
    nxt_st.stat = nxt_st.stat | events;
    if (mask_wr) begin
      nxt_st.mask = wdata;
    end
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{stat: IRQ_STAT_RST, mask: IRQ_MASK_RST, irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stat = st_ff.stat;
  assign mask = st_ff.mask;
  assign irq  = st_ff.irq;

endmodule : flag_irq

`default_nettype wire

// >>> logic/cpu_status_flag_register.sv
// top: cpu status register flag logic with APB access and interrupt
//
// Implementation choices: the register addresses and the APB slave port.
`default_nettype none

module cpu_status_flag_register (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // core datapath
  input  wire status_flag_pkg::alu_result_s   alu_res,
  input  wire logic                           loop_active,
  input  wire logic                           prio_wr,
  input  wire logic [2:0]                     prio_wdata,
  // flag outputs
  output logic [15:0]                         cpu_status_reg,
  output logic [2:0]                          cpu_priority_level,
  output logic                                irq
);
  import status_flag_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic             acc_a_overflow;
    logic             acc_b_overflow;
    logic             acc_a_saturated_sticky;
    logic             acc_b_saturated_sticky;
    logic             loop_active;
    logic             half_carry_flag;
    logic [PRIO_W-1:0] prio;
  } sr_state_s;

  sr_state_s st_ff;
  sr_state_s nxt_st;

  apb_req_s        req;
  apb_rsp_s        rsp;
  logic            wr_stb;
  logic [11:0]     wr_addr;
  logic [31:0]     wr_data;
  logic [31:0]     rd_data;
  logic [11:0]     rd_addr;
  logic            addr_hit;
  sr_write_s       sw;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_stat;
  logic [EV_W-1:0] ev_mask;
  logic [15:0]     sr_view;

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [11:0] a);
    hit = (a == STATUS_OFF) || (a == IRQ_STAT_OFF) || (a == IRQ_MASK_OFF);
  endfunction : hit

  // carry of the low-order bit: 8th for words, 4th for bytes
  function automatic logic half_carry(input alu_result_s r);
    half_carry = (r.size == SIZE_BYTE) ? r.carry_vec[3] : r.carry_vec[7];
  endfunction : half_carry

  function automatic logic [15:0] pack_sr(input sr_state_s s);
    logic [15:0] v;
    v = STATUS_RST;
    v[ACC_A_OVF_BIT]  = s.acc_a_overflow;
    v[ACC_B_OVF_BIT]  = s.acc_b_overflow;
    v[ACC_A_SAT_BIT]  = s.acc_a_saturated_sticky;
    v[ACC_B_SAT_BIT]  = s.acc_b_saturated_sticky;
    v[ANY_OVF_BIT]    = s.acc_a_overflow | s.acc_b_overflow;
    v[ANY_SAT_BIT]    = s.acc_a_saturated_sticky | s.acc_b_saturated_sticky;
    v[LOOP_BIT]       = s.loop_active;
    v[HALF_CARRY_BIT] = s.half_carry_flag;
    v[PRIO_LSB +: PRIO_W] = s.prio;
    pack_sr = v;
  endfunction : pack_sr

  // ==========================================================
  // bus front end
  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  apb_reg_if u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .req      (req),
    .rsp      (rsp),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data),
    .addr_hit (addr_hit),
    .rd_addr  (rd_addr)
  );

  assign addr_hit = hit(paddr);
  assign prdata   = rsp.prdata;
  assign pready   = rsp.pready;
  assign pslverr  = rsp.pslverr;

  assign sr_view = pack_sr(st_ff);

  always_comb begin
    rd_data = 32'h00000000;
    unique case (rd_addr)
      STATUS_OFF:   rd_data[15:0]     = sr_view;
      IRQ_STAT_OFF: rd_data[EV_W-1:0] = ev_stat;
      IRQ_MASK_OFF: rd_data[EV_W-1:0] = ev_mask;
      default:      rd_data = 32'h00000000;
    endcase
  end

  assign sw.wr   = wr_stb && (wr_addr == STATUS_OFF);
  assign sw.data = wr_data[15:0];

  // ==========================================================
  // flag update
  always_comb begin
    nxt_st = st_ff;
    nxt_st.loop_active = loop_active;
    // software write: sticky bits take written values while bit 10 is written 1, else both clear
    if (sw.wr) begin
      nxt_st.acc_a_overflow         = sw.data[ACC_A_OVF_BIT];
      nxt_st.acc_b_overflow         = sw.data[ACC_B_OVF_BIT];
      nxt_st.acc_a_saturated_sticky = sw.data[ACC_A_SAT_BIT];
      nxt_st.acc_b_saturated_sticky = sw.data[ACC_B_SAT_BIT];
      nxt_st.half_carry_flag        = sw.data[HALF_CARRY_BIT];
      nxt_st.prio                   = sw.data[PRIO_LSB +: PRIO_W];
      if (!sw.data[ANY_SAT_BIT]) begin
        nxt_st.acc_a_saturated_sticky = 1'b0;
        nxt_st.acc_b_saturated_sticky = 1'b0;
      end
    end
    if (prio_wr) begin
      nxt_st.prio = prio_wdata;
    end
    // core results; saturation set wins over a software clear
    if (alu_res.valid) begin
      nxt_st.acc_a_overflow  = alu_res.ovf_a;
      nxt_st.acc_b_overflow  = alu_res.ovf_b;
      nxt_st.half_carry_flag = half_carry(alu_res);
      if (alu_res.sat_a) begin
        nxt_st.acc_a_saturated_sticky = 1'b1;
      end
      if (alu_res.sat_b) begin
        nxt_st.acc_b_saturated_sticky = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{prio: PRIO_RST, default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // interrupt events
  assign ev[EV_OVF_A] = alu_res.valid & alu_res.ovf_a;
  assign ev[EV_OVF_B] = alu_res.valid & alu_res.ovf_b;
  assign ev[EV_SAT_A] = alu_res.valid & alu_res.sat_a;
  assign ev[EV_SAT_B] = alu_res.valid & alu_res.sat_b;

  flag_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (ev),
    .stat_wr (wr_stb && (wr_addr == IRQ_STAT_OFF)),
    .mask_wr (wr_stb && (wr_addr == IRQ_MASK_OFF)),
    .wdata   (wr_data[EV_W-1:0]),
    .stat    (ev_stat),
    .mask    (ev_mask),
    .irq     (irq)
  );

  assign cpu_status_reg     = sr_view;
  assign cpu_priority_level = st_ff.prio;

endmodule : cpu_status_flag_register

`default_nettype wire

// >>> tb/cpu_status_flag_props.sv
// checker: status flag assertions
`default_nettype none
module cpu_status_flag_props
  import status_flag_pkg::*;
(
  // ==================== clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // bus and core inputs
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire alu_result_s alu_res,
  input wire logic        loop_active,
  input wire logic        prio_wr,
  input wire logic [2:0]  prio_wdata,
  // flag outputs
  input wire logic [15:0] cpu_status_reg,
  input wire logic [2:0]  cpu_priority_level
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic sr_wr = psel && penable && pwrite && paddr == STATUS_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ovf_a_flag_a: assert property (alu_res.valid |=> cpu_status_reg[15] == $past(alu_res.ovf_a))
    else $error("acc a overflow flag wrong");
  ovf_b_flag_a: assert property (alu_res.valid |=> cpu_status_reg[14] == $past(alu_res.ovf_b))
    else $error("acc b overflow flag wrong");
  sat_a_set_a: assert property (alu_res.valid && alu_res.sat_a |=> cpu_status_reg[13])
    else $error("acc a saturation not set");
  sat_b_set_a: assert property (alu_res.valid && alu_res.sat_b |=> cpu_status_reg[12])
    else $error("acc b saturation not set");
  any_ovf_a: assert property (cpu_status_reg[11] == (cpu_status_reg[15] | cpu_status_reg[14]))
    else $error("combined overflow wrong");
  any_sat_a: assert property (cpu_status_reg[10] == (cpu_status_reg[13] | cpu_status_reg[12]))
    else $error("combined saturation wrong");
  loop_flag_a: assert property ($past(presetn) |-> cpu_status_reg[9] == $past(loop_active))
    else $error("loop flag wrong");
  word_carry_a: assert property (alu_res.valid && alu_res.size == SIZE_WORD
    |=> cpu_status_reg[8] == $past(alu_res.carry_vec[7])) else $error("half carry wrong");
  prio_load_a: assert property (prio_wr |=> cpu_priority_level == $past(prio_wdata)
    && cpu_status_reg[7:5] == $past(prio_wdata)) else $error("priority level wrong");
  sticky_write_a: assert property (sr_wr && !alu_res.valid |=> cpu_status_reg[13:12]
    == ($past(pwdata[10]) ? $past(pwdata[13:12]) : 2'b00)) else $error("sticky write wrong");
  sticky_hold_a: assert property (cpu_status_reg[13] && !sr_wr |=> cpu_status_reg[13])
    else $error("sticky flag dropped");
endmodule : cpu_status_flag_props
bind cpu_status_flag_register cpu_status_flag_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .alu_res(alu_res), .loop_active(loop_active), .prio_wr(prio_wr), .prio_wdata(prio_wdata),
  .cpu_status_reg(cpu_status_reg), .cpu_priority_level(cpu_priority_level));
`default_nettype wire

// >>> tb/test_cpu_status_flag_register.sv
// testbench: status flag register scenarios
`default_nettype none
module test_cpu_status_flag_register;
  timeunit 1ns;
  timeprecision 1ns;
  import status_flag_pkg::*;
  // ==================== signals
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  alu_result_s alu_res = '0;
  logic        loop_active = 0;
  logic        prio_wr = 0;
  logic [2:0]  prio_wdata = '0;
  logic [15:0] sr;
  logic [2:0]  lvl;
  logic        irq;
  logic [31:0] q;
  logic        e;
  int          errors = 0;
  int          checked = 0;
  cpu_status_flag_register u_cpu_status_flag_register (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu_res(alu_res),
    .loop_active(loop_active), .prio_wr(prio_wr), .prio_wdata(prio_wdata),
    .cpu_status_reg(sr), .cpu_priority_level(lvl), .irq(irq));
  initial forever #50 pclk = ~pclk;
  // ==================== helpers
  task automatic report_and_stop;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic op(input logic [7:0] cv, input op_size_e sz, input logic [3:0] f);
    @(posedge pclk);
    alu_res <= {1'b1, sz, cv, f};
    @(posedge pclk);
    alu_res <= '0;
    #1;
  endtask : op
  // ==================== scenarios
  task automatic t_reset;
    chk(sr, 0); chk(lvl, 0); chk(irq, 0);
    for (int a = 0; a < 12; a += 4) begin
      apb(0, a[11:0], 0); chk(q, 0);
      chk(e, 0);
    end
  endtask : t_reset
  task automatic t_ovf;
    op(0, SIZE_WORD, 4'b1000); chk(sr, 16'h8800);
    op(0, SIZE_WORD, 4'b0100); chk(sr, 16'h4800);
    op(0, SIZE_WORD, 4'b0000); chk(sr, 0);
  endtask : t_ovf
  task automatic t_sat;
    apb(1, IRQ_MASK_OFF, 32'hC);
    op(0, SIZE_WORD, 4'b0010); chk(sr, 16'h2400); chk(irq, 1);
    op(0, SIZE_WORD, 4'b0000); chk(sr, 16'h2400);
    op(0, SIZE_WORD, 4'b0001); chk(sr, 16'h3400);
    apb(1, IRQ_STAT_OFF, 32'hF); #1; chk(irq, 0);
    apb(1, IRQ_MASK_OFF, 32'h0);
    op(0, SIZE_WORD, 4'b0010); chk(irq, 0);
    apb(0, IRQ_STAT_OFF, 0); chk(q, 32'h4);
    apb(1, STATUS_OFF, 0); #1; chk(sr, 0);
    apb(1, STATUS_OFF, 32'h1400); #1; chk(sr, 16'h1400);
  endtask : t_sat
  task automatic t_loop;
    @(posedge pclk); loop_active <= 1;
    @(posedge pclk); #1; chk(sr[9], 1);
    apb(1, STATUS_OFF, 0); #1; chk(sr[9], 1);
    @(posedge pclk); loop_active <= 0;
    @(posedge pclk); #1; chk(sr[9], 0);
  endtask : t_loop
  task automatic t_carry;
    op(8'h80, SIZE_WORD, 0); chk(sr[8], 1);
    op(8'h08, SIZE_BYTE, 0); chk(sr[8], 1);
    op(8'h08, SIZE_WORD, 0); chk(sr[8], 0);
  endtask : t_carry
  task automatic t_prio;
    @(posedge pclk); prio_wr <= 1; prio_wdata <= 3'h5;
    @(posedge pclk); prio_wr <= 0; #1;
    chk(lvl, 5); chk(sr[7:5], 5);
    apb(1, STATUS_OFF, 32'h60); #1; chk(lvl, 3);
  endtask : t_prio
  task automatic t_unmapped;
    apb(0, 12'h00C, 0); chk(e, 1); chk(q, 0);
  endtask : t_unmapped
  // ==================== main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset(); t_ovf(); t_sat(); t_loop(); t_carry(); t_prio(); t_unmapped();
    report_and_stop();
  end
endmodule : test_cpu_status_flag_register
`default_nettype wire
